// [inc/tfc_pkg.sv]
package tfc_pkg;
    // geometry
    localparam int unsigned H_COLS      = 132;
    localparam int unsigned V_LINES     = 128;
    localparam logic [7:0]  H_LAST_COL  = 8'h83;  // column 131, counted from zero at the margin
    localparam logic [6:0]  V_FULL      = 7'h7f;  // last count before overflow
    // character codes, seven bits
    localparam logic [6:0]  CODE_ESC    = 7'h1b;  // 033 octal
    localparam logic [6:0]  CODE_SET_HT = 7'h31;  // 061 octal
    localparam logic [6:0]  CODE_CLR_HT = 7'h32;  // 062 octal
    localparam logic [6:0]  CODE_SET_VT = 7'h33;  // 063 octal
    localparam logic [6:0]  CODE_CLR_VT = 7'h34;  // 064 octal
    localparam logic [6:0]  CODE_HT     = 7'h09;  // 011 octal
    localparam logic [6:0]  CODE_VT     = 7'h0b;  // 013 octal
    localparam logic [6:0]  CODE_FF     = 7'h0c;  // 014 octal
    localparam logic [6:0]  CODE_LF     = 7'h0a;  // 0001010
    localparam logic [6:0]  CODE_CR     = 7'h0d;
    localparam logic [6:0]  CODE_BS     = 7'h08;
    localparam logic [6:0]  CODE_DEL    = 7'h7f;
    localparam logic [6:0]  CODE_SPACE  = 7'h20;  // 0100000
    // option clock of about 1.2 us per sequencer step
    localparam int unsigned CLK_NS      = 40;
    localparam int unsigned STEP_NS     = 1200;
    localparam int unsigned STEP_CYC    = STEP_NS / CLK_NS;
    localparam logic [4:0]  STEP_LAST   = 5'(STEP_CYC - 1);
    // reset values
    localparam logic [7:0]  H_RESET     = 8'h00;
    localparam logic [6:0]  V_RESET     = 7'h00;

    // what the sequencer is working on
    typedef enum logic [2:0]
    {
        TFC_IDLE  = 3'b000,  // waiting for a character
        TFC_CHAR  = 3'b001,  // four phases of a received character
        TFC_HTAB  = 3'b010,  // emitting spaces
        TFC_VTAB  = 3'b011,  // emitting line feeds to a stop
        TFC_FORM  = 3'b100,  // emitting line feeds to form origin
        TFC_HCLR  = 3'b101,  // erasing the horizontal store
        TFC_VCLR  = 3'b110   // erasing the vertical store
    } tfc_state_t;
endpackage

// [design/tfc_top.sv]
`timescale 1ns/10ps
module tfc_top
(
    input  wire logic               sys_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [6:0]         data_in,
    input  wire logic               char_available_in,
    input  wire logic [6:0]         form_preset_in,
    input  wire logic               form_origin_button_in,
    output logic      [6:0]         data_out,
    output logic                    data_oe_out,
    output logic                    char_strobe_out,
    output logic                    uart_block_out,
    output logic                    print_disable_out,
    output logic      [7:0]         hpos_out,
    output logic      [6:0]         vpos_out
);
    import tfc_pkg::*;

    tfc_state_t         state_r,   state_nxt;
    logic [4:0]         tick_r,    tick_nxt;
    logic [3:0]         phase_r,   phase_nxt;
    logic [7:0]         hcnt_r,    hcnt_nxt;
    logic [7:0]         hsave_r,   hsave_nxt;
    logic [6:0]         vcnt_r,    vcnt_nxt;
    logic [6:0]         vsave_r,   vsave_nxt;
    logic [6:0]         char_r,    char_nxt;
    logic               esc_r,     esc_nxt;
    logic               btn_r,     btn_nxt;
    logic               wake_r,    wake_nxt;
    logic [6:0]         dout_r,    dout_nxt;
    logic               oe_r,      oe_nxt;
    logic               stb_r,     stb_nxt;
    logic               hwe,       hwd;
    logic               vwe,       vwd;
    logic               step;
    logic               fwd_move;
    logic               is_lf;
    logic [H_COLS-1:0]  htab_store;
    logic [V_LINES-1:0] vtab_store;

    wire phase_one   = phase_r[0];
    wire phase_two   = phase_r[1];
    wire phase_three = phase_r[2];
    wire phase_four  = phase_r[3];

    // option clock divider; all sequencing waits on it so codes pace like the original
    assign step = (tick_r == STEP_LAST);

    // head move class of the latched character
    assign fwd_move = (char_r[6] | char_r[5]) & (char_r != CODE_DEL);
    assign is_lf    = (char_r == CODE_LF);

    // tab stores, one flip-flop per position, written from the counter address
    generate
        for (genvar i = 0; i < H_COLS; i++)
        begin : g_hstore
            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    htab_store[i] <= 1'b0;
                else if (hwe && hcnt_r == 8'(i))
                    htab_store[i] <= hwd;
            end
        end
        for (genvar j = 0; j < V_LINES; j++)
        begin : g_vstore
            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    vtab_store[j] <= 1'b0;
                else if (vwe && vcnt_r == 7'(j))
                    vtab_store[j] <= vwd;
            end
        end
    endgenerate

    // sequencer, counters, decoder and code generator
    always_comb
    begin
        state_nxt = state_r;
        tick_nxt  = step ? 5'h00 : tick_r + 5'h01;
        phase_nxt = phase_r;
        hcnt_nxt  = hcnt_r;
        hsave_nxt = hsave_r;
        vcnt_nxt  = vcnt_r;
        vsave_nxt = vsave_r;
        char_nxt  = char_r;
        esc_nxt   = esc_r;
        btn_nxt   = form_origin_button_in;
        wake_nxt  = 1'b0;
        dout_nxt  = dout_r;
        oe_nxt    = 1'b0;
        stb_nxt   = 1'b0;
        hwe       = 1'b0;
        hwd       = 1'b0;
        vwe       = 1'b0;
        vwd       = 1'b0;
        // button edge or wake-up loads the form preset; a line feed past V_FULL (LF, VT or FF) reloads it too
        if (wake_r || (form_origin_button_in && !btn_r))
            vcnt_nxt = form_preset_in;
        else if (step)
        begin
            case (state_r)
                TFC_IDLE:
                begin
                    // characters only accepted here, never mid-sequence
                    if (char_available_in)
                    begin
                        char_nxt  = data_in;
                        phase_nxt = 4'b0001;
                        state_nxt = TFC_CHAR;
                    end
                end
                TFC_CHAR:
                begin
                    phase_nxt = {phase_r[2:0], 1'b0};
                    if (phase_one)
                    begin
                        if (char_r == CODE_CR)
                            hcnt_nxt = H_RESET;
                        if (is_lf)
                        begin
                            // overflow reloads form length
                            vcnt_nxt = (vcnt_r == V_FULL) ? form_preset_in : vcnt_r + 7'h01;
                        end
                    end
                    if (phase_two && esc_r)
                    begin
                        // digit honoured only as the very next character
                        if (char_r == CODE_SET_HT)
                        begin
                            hwe = 1'b1;
                            hwd = 1'b1;
                        end
                        if (char_r == CODE_SET_VT)
                        begin
                            vwe = 1'b1;
                            vwd = 1'b1;
                        end
                    end
                    if (phase_three)
                    begin
                        // the digit itself still moves the head
                        if (char_r == CODE_BS && hcnt_r != H_RESET)
                            hcnt_nxt = hcnt_r - 8'h01;
                        else if (fwd_move && hcnt_r != H_LAST_COL)
                            hcnt_nxt = hcnt_r + 8'h01;
                    end
                    if (phase_four)
                    begin
                        state_nxt = TFC_IDLE;
                        // escape flag moves last so the clear dispatch below still sees it
                        esc_nxt   = (char_r == CODE_ESC);
                        if (char_r == CODE_HT)
                            state_nxt = TFC_HTAB;
                        else if (char_r == CODE_VT)
                            state_nxt = TFC_VTAB;
                        else if (char_r == CODE_FF)
                            state_nxt = TFC_FORM;
                        else if (esc_r && char_r == CODE_CLR_HT)
                        begin
                            hsave_nxt = hcnt_r;
                            hcnt_nxt  = H_RESET;
                            state_nxt = TFC_HCLR;
                        end
                        else if (esc_r && char_r == CODE_CLR_VT)
                        begin
                            vsave_nxt = vcnt_r;
                            vcnt_nxt  = V_RESET;
                            state_nxt = TFC_VCLR;
                        end
                    end
                end
                TFC_HTAB:
                begin
                    // stop at a set column or park at the margin
                    if (hcnt_r == H_LAST_COL || (htab_store[hcnt_r] && hcnt_r != hsave_r))
                        state_nxt = TFC_IDLE;
                    else
                    begin
                        dout_nxt  = CODE_SPACE;
                        oe_nxt    = 1'b1;
                        stb_nxt   = 1'b1;
                        hcnt_nxt  = hcnt_r + 8'h01;
                        hsave_nxt = 8'hff;
                    end
                end
                TFC_VTAB,
                TFC_FORM:
                begin
                    dout_nxt = CODE_LF;
                    oe_nxt   = 1'b1;
                    stb_nxt  = 1'b1;
                    if (vcnt_r == V_FULL)
                    begin
                        vcnt_nxt  = form_preset_in;
                        state_nxt = TFC_IDLE;
                    end
                    else
                    begin
                        vcnt_nxt = vcnt_r + 7'h01;
                        if (state_r == TFC_VTAB && vtab_store[vcnt_r + 7'h01])
                            state_nxt = TFC_IDLE;
                    end
                end
                TFC_HCLR:
                begin
                    hwe = 1'b1;
                    if (hcnt_r == H_LAST_COL)
                    begin
                        hcnt_nxt  = hsave_r;
                        state_nxt = TFC_IDLE;
                    end
                    else
                        hcnt_nxt = hcnt_r + 8'h01;
                end
                TFC_VCLR:
                begin
                    vwe = 1'b1;
                    if (vcnt_r == V_FULL)
                    begin
                        vcnt_nxt  = vsave_r;
                        state_nxt = TFC_IDLE;
                    end
                    else
                        vcnt_nxt = vcnt_r + 7'h01;
                end
                default:
                    state_nxt = TFC_IDLE;
            endcase
        end
        // a fresh HT starts its search past a stop the head sits on
        if (state_nxt == TFC_HTAB && state_r != TFC_HTAB)
            hsave_nxt = hcnt_nxt;
    end

    // register stage; wake flag pulses once after reset release
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= TFC_IDLE;
            tick_r  <= 5'h00;
            phase_r <= 4'h0;
            hcnt_r  <= H_RESET;
            hsave_r <= H_RESET;
            vcnt_r  <= V_RESET;
            vsave_r <= V_RESET;
            char_r  <= 7'h00;
            esc_r   <= 1'b0;
            btn_r   <= 1'b0;
            wake_r  <= 1'b1;
            dout_r  <= 7'h00;
            oe_r    <= 1'b0;
            stb_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            tick_r  <= tick_nxt;
            phase_r <= phase_nxt;
            hcnt_r  <= hcnt_nxt;
            hsave_r <= hsave_nxt;
            vcnt_r  <= vcnt_nxt;
            vsave_r <= vsave_nxt;
            char_r  <= char_nxt;
            esc_r   <= esc_nxt;
            btn_r   <= btn_nxt;
            wake_r  <= wake_nxt;
            dout_r  <= dout_nxt;
            oe_r    <= oe_nxt;
            stb_r   <= stb_nxt;
        end
    end

    // output flops; uart block covers every running sequence
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            uart_block_out    <= 1'b0;
            print_disable_out <= 1'b0;
        end
        else
        begin
            uart_block_out    <= (state_nxt != TFC_IDLE);
            print_disable_out <= (hcnt_nxt == H_LAST_COL);
        end
    end

    assign data_out        = dout_r;
    assign data_oe_out     = oe_r;
    assign char_strobe_out = stb_r;
    assign hpos_out        = hcnt_r;
    assign vpos_out        = vcnt_r;

    // escape prefix seen and the set digit at its second phase, no preset load stealing the step
    sequence s_set_htab_cmd;
        state_r == TFC_CHAR && step && phase_two && esc_r && char_r == CODE_SET_HT
            && !wake_r && !(form_origin_button_in && !btn_r);
    endsequence

    a_set_htab_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        s_set_htab_cmd |=> htab_store[$past(hcnt_r)])
        else $error("set tab did not store column");
    a_space_code: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (data_oe_out && state_r == TFC_HTAB) |-> data_out == CODE_SPACE)
        else $error("wrong space code");
    a_hpos_bound: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        hpos_out <= H_LAST_COL)
        else $error("column beyond margin");
    a_print_off_last: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (hpos_out == H_LAST_COL) |-> print_disable_out)
        else $error("printing enabled at last column");
    a_block_input: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_r != TFC_IDLE) |-> uart_block_out)
        else $error("uart not blocked");
    a_lf_advance: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_r == TFC_FORM && step && vcnt_r != V_FULL && !wake_r && !(form_origin_button_in && !btn_r))
        |=> vcnt_r == $past(vcnt_r) + 7'h01)
        else $error("line feed did not advance");
    a_gen_drive: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        data_oe_out |-> char_strobe_out)
        else $error("drive without strobe");
    a_step_rate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        step |=> !step [*8])
        else $error("sequencer stepped too fast");
endmodule

// [bench/tfc_uart_model.sv]
`timescale 1ns/10ps
// far side: uart and character buffer handing over one character at a time
module tfc_uart_model
(
    input  wire logic        clk_in,
    input  wire logic        block_in,
    output logic             avail_out,
    output logic [6:0]       data_out
);
    initial
    begin
        avail_out = 1'b0;
        data_out  = 7'h55;
    end

    // hold the character until the option blocks the uart; gap gives slow or prompt delivery
    task automatic send(input logic [6:0] code, input int gap);
        int n;
        @(posedge clk_in);
        repeat (gap) @(posedge clk_in);
        avail_out <= 1'b1;
        data_out  <= code;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (block_in !== 1'b1 && n < 200);
        avail_out <= 1'b0;
        data_out  <= ~code;  // released lines must not keep the old character
        n = 0;
        while (block_in === 1'b1 && n < 6000)
        begin
            @(posedge clk_in);
            n++;
        end
        @(posedge clk_in);
    endtask
endmodule

// [bench/tab_and_forms_control_tb_top.sv]
`timescale 1ns/10ps
// reference model in integers, compared with the design after every character
module tab_and_forms_control_tb_top;
    import tfc_pkg::*;

    logic        sys_clk_in;
    logic        rst_n_in;
    logic [6:0]  data_in;
    logic [6:0]  uart_data;
    logic        char_available_in;
    logic [6:0]  form_preset_in;
    logic        form_origin_button_in;
    logic [6:0]  data_out;
    logic        data_oe_out;
    logic        char_strobe_out;
    logic        uart_block_out;
    logic        print_disable_out;
    logic [7:0]  hpos_out;
    logic [6:0]  vpos_out;
    int          failures;
    int          n_checks;
    int          n_sp;
    int          n_lf;
    int          n_st;
    int          n_bad;
    int          h;
    int          v;
    int          pre;
    bit          esc;
    bit          hst [0:H_COLS-1];
    bit          vst [0:127];
    logic [31:0] rnd;

    // shared data lines: the generated code wins while the option drives
    assign data_in = data_oe_out ? data_out : uart_data;

    initial
    begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    tfc_top DUT
    (
        .sys_clk_in            (sys_clk_in),
        .rst_n_in              (rst_n_in),
        .data_in               (data_in),
        .char_available_in     (char_available_in),
        .form_preset_in        (form_preset_in),
        .form_origin_button_in (form_origin_button_in),
        .data_out              (data_out),
        .data_oe_out           (data_oe_out),
        .char_strobe_out       (char_strobe_out),
        .uart_block_out        (uart_block_out),
        .print_disable_out     (print_disable_out),
        .hpos_out              (hpos_out),
        .vpos_out              (vpos_out)
    );

    tfc_uart_model PTN
    (
        .clk_in    (sys_clk_in),
        .block_in  (uart_block_out),
        .avail_out (char_available_in),
        .data_out  (uart_data)
    );

    // tally generated codes; anything but space or line feed is wrong
    always @(posedge sys_clk_in)
    begin
        if (char_strobe_out === 1'b1)
            n_st++;
        if (data_oe_out === 1'b1)
        begin
            if (data_out === CODE_SPACE)
                n_sp++;
            else if (data_out === CODE_LF)
                n_lf++;
            else
                n_bad++;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // one line feed in the model; returns 1 when the form origin is reached
    function automatic bit adv();
        if (v == 127)
        begin
            v = pre;
            return 1'b1;
        end
        v++;
        return 1'b0;
    endfunction

    // model one character, hand it over, then compare uart block, positions and generated code tallies
    task automatic tx(input logic [6:0] c);
        int sp;
        int lf;
        sp = 0;
        lf = 0;
        if (esc && c == CODE_SET_HT) hst[h] = 1'b1;
        if (esc && c == CODE_SET_VT) vst[v] = 1'b1;
        if (esc && c == CODE_CLR_HT) hst = '{default: 1'b0};
        if (esc && c == CODE_CLR_VT) vst = '{default: 1'b0};
        esc = (c == CODE_ESC);
        if (c == CODE_CR) h = 0;
        if (c == CODE_BS && h > 0) h--;
        if ((c[5] | c[6]) && c != CODE_DEL && h < H_LAST_COL) h++;
        if (c == CODE_LF) void'(adv());
        while (c == CODE_HT && h < H_LAST_COL)
        begin
            h++;
            sp++;
            if (hst[h]) break;
        end
        if (c == CODE_FF)
            do lf++; while (!adv());
        if (c == CODE_VT)
            do lf++; while (!adv() && !vst[v]);
        n_sp = 0;
        n_lf = 0;
        n_st = 0;
        n_bad = 0;
        PTN.send(c, 9 * rnd[2:0]);
        rnd = lfsr(rnd);
        @(negedge sys_clk_in);
        check("uart_block", uart_block_out, 0);
        check("hpos", hpos_out, h);
        check("vpos", vpos_out, v);
        check("spaces", n_sp, sp);
        check("line_feeds", n_lf, lf);
        check("strobes", n_st, sp + lf);
        check("other_codes", n_bad, 0);
    endtask

    task automatic run(input string name, input logic [6:0] q [$]);
        foreach (q[i]) tx(q[i]);
        $display("test %s done, checks %0d failures %0d", name, n_checks, failures);
    endtask

    // new form length from the selector, loaded by the button
    task automatic press(input logic [6:0] p);
        @(posedge sys_clk_in);
        form_preset_in <= p;
        @(posedge sys_clk_in);
        form_origin_button_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        form_origin_button_in <= 1'b0;
        pre = p;
        v = p;
        repeat (2) @(negedge sys_clk_in);
        check("vpos_preset", vpos_out, p);
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // runs take about 38k cycles; two and a half times that means a hang
    initial
    begin
        repeat (95000) @(posedge sys_clk_in);
        failures++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial
    begin
        rst_n_in = 1'b0;
        form_preset_in = 7'h2c;
        form_origin_button_in = 1'b0;
        failures = 0;
        n_checks = 0;
        rnd = 32'h3002a571;
        esc = 1'b0;
        h = 0;
        pre = 44;
        v = 44;
        hst = '{default: 1'b0};
        vst = '{default: 1'b0};
        repeat (5) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(negedge sys_clk_in);
        check("hpos_reset", hpos_out, 0);
        check("vpos_wake", vpos_out, 44);
        repeat (10) tx(7'h20 + 7'(rnd % 95));
        $display("test reset_random done, checks %0d failures %0d", n_checks, failures);
        run("head_moves", '{CODE_BS, CODE_DEL, CODE_BS, CODE_CR, CODE_BS, 7'h78});
        run("set_htabs", '{CODE_ESC, CODE_SET_HT, 7'h41, 7'h42, 7'h43, CODE_ESC, 7'h41, CODE_SET_HT,
            CODE_ESC, CODE_SET_HT, 7'h44, 7'h45, CODE_CR, CODE_HT, CODE_HT, CODE_HT, 7'h5a});
        check("print_off", print_disable_out, 1);
        run("margin", '{CODE_CR, CODE_HT});
        check("print_on", print_disable_out, 0);
        run("clear_htabs", '{CODE_ESC, CODE_CLR_HT, CODE_CR, CODE_HT, CODE_CR});
        run("vtabs", '{CODE_LF, CODE_LF, CODE_LF, CODE_ESC, CODE_SET_VT, CODE_FF, CODE_VT, CODE_VT,
            CODE_ESC, CODE_CLR_VT, CODE_LF, CODE_VT});
        press(7'h64);
        tx(CODE_FF);
        repeat (28) tx(CODE_LF);
        $display("test form_length done, checks %0d failures %0d", n_checks, failures);
        report_and_stop();
    end
endmodule
